// ---- design/rcpt_pkg.sv ----
// package: register map, field positions, resets and carriers for coexistence_arbiter block
package rcpt_pkg;
	localparam logic [31:0] ADDR_PRIO_A = 32'h4000_0108;
	localparam logic [31:0] ADDR_PRIO_B = 32'h4000_010C;
	localparam logic [31:0] ADDR_CTRL2 = 32'h4000_0200;
	localparam logic [31:0] ADDR_FETCH = 32'h4000_00F0;
	localparam logic [31:0] RST_PRIO_A = 32'h3489_ADEF;
	localparam logic [3:0] RST_FALLBACK = 4'h3;
	localparam logic [8:0] RST_FETCH = 9'h096;
	localparam int POS_FALLBACK = 28;
	localparam int POS_START = 22;
	localparam int BIT_RSSI_SEL = 21;
	localparam int BIT_WAKE_STAT = 20;
	localparam int BIT_PTI_SRC = 17;
	localparam int BIT_GLITCH = 16;
	localparam int BIT_ASSERT_COND = 15;
	localparam int NUM_CLASSES = 8;
	localparam int PRIO_W = 4;

	typedef struct packed {
		logic [9:0] transaction_start_slot;
		logic signal_strength_select;
		logic pti_source_select;
		logic transaction_glitch_mode;
		logic transaction_assert_condition;
	} rcpt_ctrl_t;

	typedef struct packed {
		logic [3:0] pti;
		logic pti_valid;
	} rcpt_pti_t;
endpackage

// ---- design/rcpt_core.sv ----
// module: coexistence priority table, transaction generator, apb registers
//
// Behaviour
// - passive scan priority, top nibble, reset 3
// - nonconnectable advertising priority, bits 27:24, reset 4
// - connectable advertising priority, bits 23:20, reset 8
// - active scan priority, bits 19:16, reset 9
// - initiating scan priority, bits 15:12, reset 10
// - data channel priority, bits 11:8, reset 13
// - link control priority, bits 7:4, reset 14
// - connection request priority, bits 3:0, reset 15
// - fallback priority when msg_class_valid is low, reset 3
// - start slot matches fine counter asserts transaction
// - event end drops transaction signal
// - rssi select: peak hold or average
// - wake status readable; handler waits clear
// - wake auto acknowledged two lp ticks after power up
// - pti source: control structure or dynamic
// - glitch mode clear keeps transaction steady
// - glitch mode set: one low cycle per change
// - condition clear: need pti, else tx/rx edge
// - condition set: need event, else tx/rx edge
// - event indication from fetch instant, reset 0x96
`timescale 1ns/1ps
module rcpt_core
	import rcpt_pkg::*;
#(
	parameter int FINE_W = 10
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link layer timing
	input wire logic [FINE_W-1:0] fine_slot_counter,
	input wire logic [8:0] event_fine_time,
	input wire logic event_active,
	input wire logic tx_en,
	input wire logic rx_en,
	input wire logic [2:0] msg_class,
	input wire logic msg_class_valid,
	input wire rcpt_pkg::rcpt_pti_t cs_pti,
	input wire rcpt_pkg::rcpt_pti_t dyn_pti,
	// signal strength sources
	input wire logic [7:0] rssi_peak,
	input wire logic [7:0] rssi_avg,
	// low power wake
	input wire logic lowpower_wake_interrupt,
	input wire logic radio_powered,
	input wire logic lp_clk_tick,
	// toward coexistence arbiter
	output logic coexistence_arbiter_transaction_signal,
	output logic [3:0] coexistence_arbiter_pti,
	output logic [3:0] msg_priority,
	output logic [7:0] rssi_report,
	output logic event_in_process
);
	import rcpt_pkg::*;

	if (FINE_W != 10) begin : g_bad_fine_w
		$error("fine counter must be 10 bits");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT_EDGE = 3'b010,
		ST_ACTIVE = 3'b100
	} rcpt_state_t;

	logic [31:0] prio_a_q;
	logic [3:0] fallback_q;
	rcpt_ctrl_t ctrl_q;
	logic [8:0] fetch_q;
	logic wake_stat_q;
	logic [1:0] wake_ack_q;
	rcpt_state_t st_q, st_d;
	logic trans_q, trans_d;
	logic [3:0] pti_q;
	logic tx_q, rx_q;
	logic [31:0] rdata_d;
	logic [PRIO_W-1:0] class_prio [NUM_CLASSES];

	// each class field is one nibble of the first table register
	genvar g;
	generate
		for (g = 0; g < NUM_CLASSES; g++) begin : g_cls
			assign class_prio[g] = prio_a_q[g*PRIO_W +: PRIO_W];
		end
	endgenerate

	wire apb_wr = psel && penable && pwrite;
	wire hit_a = paddr == ADDR_PRIO_A;
	wire hit_b = paddr == ADDR_PRIO_B;
	wire hit_c = paddr == ADDR_CTRL2;
	wire hit_f = paddr == ADDR_FETCH;
	wire hit_any = hit_a || hit_b || hit_c || hit_f;

	wire rcpt_pti_t pti_sel = ctrl_q.pti_source_select ? dyn_pti : cs_pti;
	wire tr_edge = (tx_en && !tx_q) || (rx_en && !rx_q);
	wire slot_hit = fine_slot_counter == ctrl_q.transaction_start_slot;
	wire start_ok = ctrl_q.transaction_assert_condition ? event_in_process
		: pti_sel.pti_valid;
	wire pti_change = pti_sel.pti_valid && (pti_sel.pti != pti_q);

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_a) begin
			rdata_d = prio_a_q;
		end
		if (hit_b) begin
			rdata_d[POS_FALLBACK +: 4] = fallback_q;
		end
		if (hit_c) begin
			rdata_d[POS_START +: 10] = ctrl_q.transaction_start_slot;
			rdata_d[BIT_RSSI_SEL] = ctrl_q.signal_strength_select;
			rdata_d[BIT_WAKE_STAT] = wake_stat_q;
			rdata_d[BIT_PTI_SRC] = ctrl_q.pti_source_select;
			rdata_d[BIT_GLITCH] = ctrl_q.transaction_glitch_mode;
			rdata_d[BIT_ASSERT_COND] = ctrl_q.transaction_assert_condition;
		end
		if (hit_f) begin
			rdata_d[8:0] = fetch_q;
		end
	end

	// apb: zero wait, answer in the access cycle
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit_any;
			prdata <= rdata_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prio_a_q <= RST_PRIO_A;
			fallback_q <= RST_FALLBACK;
			ctrl_q <= '0;
			fetch_q <= RST_FETCH;
		end else if (apb_wr && pready) begin
			if (hit_a) prio_a_q <= pwdata;
			if (hit_b) fallback_q <= pwdata[POS_FALLBACK +: 4];
			if (hit_f) fetch_q <= pwdata[8:0];
			if (hit_c) begin
				ctrl_q.transaction_start_slot <= pwdata[POS_START +: 10];
				ctrl_q.signal_strength_select <= pwdata[BIT_RSSI_SEL];
				ctrl_q.pti_source_select <= pwdata[BIT_PTI_SRC];
				ctrl_q.transaction_glitch_mode <= pwdata[BIT_GLITCH];
				ctrl_q.transaction_assert_condition <= pwdata[BIT_ASSERT_COND];
			end
		end
	end

	// wake status set by interrupt; set wins over auto clear
	// auto ack after power up plus two lp ticks
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wake_stat_q <= 1'b0;
			wake_ack_q <= 2'b00;
		end else begin
			if (!wake_stat_q || !radio_powered) begin
				wake_ack_q <= 2'b00;
			end else if (lp_clk_tick && wake_ack_q != 2'b10) begin
				wake_ack_q <= wake_ack_q + 2'b01;
			end
			if (lowpower_wake_interrupt) begin
				wake_stat_q <= 1'b1;
			end else if (wake_ack_q == 2'b10) begin
				wake_stat_q <= 1'b0;
			end
		end
	end

	always_comb begin
		st_d = st_q;
		trans_d = trans_q;
		unique case (st_q)
			ST_IDLE: begin
				trans_d = 1'b0;
				if (event_active && slot_hit) begin
					if (start_ok) begin
						st_d = ST_ACTIVE;
						trans_d = 1'b1;
					end else begin
						st_d = ST_WAIT_EDGE;
					end
				end
			end
			ST_WAIT_EDGE: begin
				// fall back to tx/rx rising edge
				// only an event that is no longer scheduled gives up
				if (!event_active) begin
					st_d = ST_IDLE;
				end else if (tr_edge) begin
					st_d = ST_ACTIVE;
					trans_d = 1'b1;
				end
			end
			ST_ACTIVE: begin
				trans_d = 1'b1;
				if (!event_in_process) begin
					st_d = ST_IDLE;
					trans_d = 1'b0;
				// one low cycle on pti change
				end else if (ctrl_q.transaction_glitch_mode && pti_change) begin
					trans_d = 1'b0;
				end
			end
			default: begin
				st_d = ST_IDLE;
				trans_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			trans_q <= 1'b0;
			pti_q <= 4'h0;
			tx_q <= 1'b0;
			rx_q <= 1'b0;
			coexistence_arbiter_pti <= 4'h0;
			msg_priority <= 4'h0;
			rssi_report <= 8'h00;
			event_in_process <= 1'b0;
		end else begin
			st_q <= st_d;
			trans_q <= trans_d;
			tx_q <= tx_en;
			rx_q <= rx_en;
			if (pti_sel.pti_valid) pti_q <= pti_sel.pti;
			coexistence_arbiter_pti <= pti_sel.pti;
			msg_priority <= msg_class_valid ? class_prio[msg_class] : fallback_q;
			rssi_report <= ctrl_q.signal_strength_select ? rssi_avg : rssi_peak;
			// event window opens at fetch instant
			event_in_process <= event_active && (event_fine_time >= fetch_q);
		end
	end

	assign coexistence_arbiter_transaction_signal = trans_q;

	a_trans_end_drop: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		st_q == ST_ACTIVE && !event_in_process |=> !coexistence_arbiter_transaction_signal)
		else $error("transaction stayed high after event end");
	// single low cycle in glitch mode
	a_glitch_one_low: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		st_q == ST_ACTIVE && event_in_process && pti_change
		&& ctrl_q.transaction_glitch_mode |=> !coexistence_arbiter_transaction_signal)
		else $error("no low pulse on pti change");
	a_trans_steady: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		st_q == ST_ACTIVE && event_in_process
		&& !ctrl_q.transaction_glitch_mode |=> coexistence_arbiter_transaction_signal)
		else $error("transaction dropped inside event");
	a_start_assert: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		st_q == ST_IDLE && event_active && slot_hit && start_ok
		|=> coexistence_arbiter_transaction_signal)
		else $error("transaction not raised at start slot");
	a_wait_edge: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		st_q == ST_IDLE && event_active && slot_hit && !start_ok
		|=> !coexistence_arbiter_transaction_signal)
		else $error("transaction raised without condition");
	// tx/rx edge starts a waiting transaction
	a_wait_edge_go: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		st_q == ST_WAIT_EDGE && event_active && tr_edge
		|=> coexistence_arbiter_transaction_signal)
		else $error("transaction not raised at tx/rx edge");
	a_rssi_select: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!ctrl_q.signal_strength_select |=> rssi_report == $past(rssi_peak))
		else $error("wrong rssi flavour");
	a_rssi_average: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ctrl_q.signal_strength_select |=> rssi_report == $past(rssi_avg))
		else $error("average rssi not reported");
	a_pti_dynamic: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ctrl_q.pti_source_select |=> coexistence_arbiter_pti == $past(dyn_pti.pti))
		else $error("dynamic pti not passed");
	a_pti_control: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!ctrl_q.pti_source_select |=> coexistence_arbiter_pti == $past(cs_pti.pti))
		else $error("control structure pti not passed");
	a_wake_set: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		lowpower_wake_interrupt |=> wake_stat_q)
		else $error("wake status not set");
	// wake status clears after ack sequence
	a_wake_ack: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		wake_ack_q == 2'b10 && !lowpower_wake_interrupt |=> !wake_stat_q)
		else $error("wake status not acknowledged");
	// event window opens at fetch instant
	a_event_window: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		event_active && event_fine_time >= fetch_q |=> event_in_process)
		else $error("event indication not raised");
	a_class_prio: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		msg_class_valid
		|=> msg_priority == $past(prio_a_q[{msg_class, 2'b00} +: PRIO_W]))
		else $error("class priority not applied");
	a_fallback_prio: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!msg_class_valid |=> msg_priority == $past(fallback_q))
		else $error("fallback priority not applied");
endmodule // rcpt_core

// ---- tb/rcpt_arb_model.sv ----
// coexistence arbiter model: counts granted transactions
`timescale 1ns/1ps
module rcpt_arb_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// from the priority block
	input wire logic coexistence_arbiter_transaction_signal,
	input wire logic [3:0] coexistence_arbiter_pti,
	// to the bench
	output int grants,
	output logic [3:0] last_pti
);
	logic prev_q;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prev_q <= 1'b0;
			grants <= 0;
			last_pti <= 4'h0;
		end else begin
			prev_q <= coexistence_arbiter_transaction_signal;
			if (coexistence_arbiter_transaction_signal && !prev_q) begin
				grants <= grants + 1;
				last_pti <= coexistence_arbiter_pti;
			end
		end
	end
endmodule // rcpt_arb_model

// ---- tb/tb_top.sv ----
// self-checking bench for the coexistence priority block
`timescale 1ns/1ps
module tb_top;
	import rcpt_pkg::*;
	logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [9:0] fine_slot_counter;
	logic [8:0] event_fine_time;
	logic event_active, tx_en, rx_en, msg_class_valid, event_in_process;
	logic [2:0] msg_class;
	rcpt_pti_t cs_pti, dyn_pti;
	logic [7:0] rssi_peak, rssi_avg, rssi_report;
	logic lowpower_wake_interrupt, radio_powered, lp_clk_tick;
	logic coexistence_arbiter_transaction_signal;
	logic [3:0] coexistence_arbiter_pti, msg_priority, last_pti;
	int mismatches = 0, num_checks = 0, cyc = 0, grants, lows, g0;

	rcpt_core uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .fine_slot_counter,
		.event_fine_time, .event_active, .tx_en, .rx_en, .msg_class,
		.msg_class_valid, .cs_pti, .dyn_pti, .rssi_peak, .rssi_avg,
		.lowpower_wake_interrupt, .radio_powered, .lp_clk_tick,
		.coexistence_arbiter_transaction_signal, .coexistence_arbiter_pti, .msg_priority, .rssi_report,
		.event_in_process);
	rcpt_arb_model arb (.sys_clk, .nrst, .coexistence_arbiter_transaction_signal,
		.coexistence_arbiter_pti, .grants, .last_pti);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			complete_run;
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task cy(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// request held until pready is sampled high
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// slot 5 = off distance 2 + power-up max(4, 3) - 1
	task pulse_slot;
		fine_slot_counter <= 10'h005;
		@(posedge sys_clk);
		fine_slot_counter <= 10'h000;
	endtask

	task t_reset;
		apb(1'b0, ADDR_PRIO_A, 32'h0);
		chk(rd, 32'h3489_ADEF);
		apb(1'b0, ADDR_PRIO_B, 32'h0);
		chk(rd[31:28], 4'h3);
		apb(1'b0, ADDR_CTRL2, 32'h0);
		chk(rd[21:15], 7'h00);
		apb(1'b1, 32'h4000_0300, 32'hFFFF_FFFF);
		chk(err, 1'b1);
		apb(1'b0, 32'h4000_0300, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_FETCH, 32'h0);
		chk(rd, 32'(RST_FETCH));
		$display("test reset done");
	endtask

	task t_prio;
		apb(1'b1, ADDR_PRIO_A, 32'h0123_4567);
		apb(1'b1, ADDR_PRIO_B, 32'h5000_0000);
		apb(1'b0, ADDR_PRIO_A, 32'h0);
		chk(rd, 32'h0123_4567);
		msg_class_valid <= 1'b1;
		for (int c = 0; c < 8; c++) begin
			msg_class <= 3'(c);
			cy(2);
			chk(msg_priority, 4'(32'h0123_4567 >> (4 * c)));
		end
		msg_class_valid <= 1'b0;
		cy(2);
		chk(msg_priority, 4'h5);
		$display("test priority done");
	endtask

	// a second reset restores the reset values of the tables
	task t_rerst;
		nrst <= 1'b0;
		cy(2);
		nrst <= 1'b1;
		apb(1'b0, ADDR_PRIO_A, 32'h0);
		chk(rd, RST_PRIO_A);
		apb(1'b0, ADDR_PRIO_B, 32'h0);
		chk(rd[31:28], RST_FALLBACK);
		chk(msg_priority, RST_FALLBACK);
		$display("test second reset done");
	endtask

	task t_sel;
		{rssi_peak, rssi_avg} <= 16'h1122;
		{cs_pti, dyn_pti} <= {4'h6, 1'b1, 4'h9, 1'b1};
		apb(1'b1, ADDR_CTRL2, 32'h0);
		cy(2);
		chk(rssi_report, 8'h11);
		chk(coexistence_arbiter_pti, 4'h6);
		apb(1'b1, ADDR_CTRL2, 32'h0022_0000);
		cy(2);
		chk(rssi_report, 8'h22);
		chk(coexistence_arbiter_pti, 4'h9);
		$display("test select done");
	endtask

	// start slot 5 comes after the fetch instant (event time 0xA0 above 0x96)
	task t_trans(input logic [31:0] mode);
		apb(1'b1, ADDR_CTRL2, mode);
		{cs_pti, event_active, event_fine_time} <= {5'h0D, 1'b1, 9'h0A0};
		g0 = grants;
		cy(3);
		chk(coexistence_arbiter_transaction_signal, 1'b0);
		chk(event_in_process, 1'b1);
		pulse_slot;
		cy(2);
		chk(coexistence_arbiter_transaction_signal, 1'b1);
		lows = 0;
		cs_pti <= {4'h7, 1'b1};
		repeat (6) begin
			@(posedge sys_clk);
			lows += int'(coexistence_arbiter_transaction_signal === 1'b0);
		end
		chk(lows, mode[16]);
		chk(grants - g0, 1 + mode[16]);
		chk(last_pti, mode[16] ? 4'h7 : 4'h6);
		event_active <= 1'b0;
		cy(4);
		chk(coexistence_arbiter_transaction_signal, 1'b0);
		$display("test transaction done");
	endtask

	task t_late(input logic [31:0] mode);
		apb(1'b1, ADDR_CTRL2, mode);
		{cs_pti, event_active, event_fine_time} <= {5'h06, 1'b1, 9'h000};
		cy(2);
		pulse_slot;
		cy(3);
		chk(coexistence_arbiter_transaction_signal, 1'b0);
		chk(event_in_process, 1'b0);
		event_fine_time <= 9'h0A0;
		cy(3);
		{tx_en, rx_en} <= {mode[15], ~mode[15]};
		cy(3);
		chk(coexistence_arbiter_transaction_signal, 1'b1);
		{tx_en, rx_en, event_active} <= 3'b000;
		cy(4);
		chk(coexistence_arbiter_transaction_signal, 1'b0);
		$display("test late start done");
	endtask

	task t_wake;
		lowpower_wake_interrupt <= 1'b1;
		@(posedge sys_clk);
		lowpower_wake_interrupt <= 1'b0;
		apb(1'b1, ADDR_CTRL2, 32'h0);
		apb(1'b0, ADDR_CTRL2, 32'h0);
		chk(rd[20], 1'b1);
		radio_powered <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			lp_clk_tick <= 1'b1;
			@(posedge sys_clk);
			lp_clk_tick <= 1'b0;
			cy(2);
			apb(1'b0, ADDR_CTRL2, 32'h0);
			chk(rd[20], k == 0);
		end
		$display("test wake done");
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, fine_slot_counter} = '0;
		{event_fine_time, event_active, tx_en, rx_en, msg_class} = '0;
		{msg_class_valid, cs_pti, dyn_pti, rssi_peak, rssi_avg} = '0;
		{lowpower_wake_interrupt, radio_powered, lp_clk_tick} = '0;
		nrst = 1'b0;
		cy(20);
		nrst <= 1'b1;
		t_reset;
		t_prio;
		t_rerst;
		t_sel;
		t_trans(32'h0140_0000);
		t_trans(32'h0140_8000);
		t_trans(32'h0141_0000);
		t_late(32'h0140_0000);
		t_late(32'h0140_8000);
		t_wake;
		complete_run;
	end
endmodule // tb_top
